/* File: core/irq_ctrl_consts.svh */
// Constants for the interrupt enable and priority register block.
// Assumes a 32-bit AXI4-Lite register port and 16-bit registers.
`ifndef IRQ_CTRL_CONSTS_SVH
`define IRQ_CTRL_CONSTS_SVH

// Register byte offsets
`define OFS_ENABLE_0        8'h00
`define OFS_ENABLE_6        8'h04
`define OFS_PRIORITY_13     8'h08
`define OFS_IRQ_STATUS      8'h0C
`define OFS_IRQ_MASK        8'h10

// Implemented bits of each register
`define IMPL_ENABLE_0       16'h0007
`define IMPL_ENABLE_6       16'hC38F
`define IMPL_PRIORITY_13    16'h0770
`define IMPL_IRQ_BITS       16'h3FFF

// Reset values
`define RST_ENABLE          16'h0000
`define RST_PRIORITY_13     16'h0440
`define RST_IRQ_MASK        16'h0000

// Field positions
`define POS_OUT_CMP1        2
`define POS_IN_CAP1         1
`define POS_EXT_IRQ0        0
`define POS_ADC_PAIR1       15
`define POS_ADC_PAIR0       14
`define POS_CMP4            9
`define POS_CMP3            8
`define POS_CMP2            7
`define POS_PWM6            3
`define POS_PWM5            2
`define POS_PWM4            1
`define POS_PWM3            0
`define POS_EXT4_PRIO       8
`define POS_EXT3_PRIO       4

// AXI responses
`define RESP_OKAY           2'h0
`define RESP_DECERR         2'h3

`endif

/* File: core/irq_ctrl_pkg.sv */
// Types shared by the interrupt enable and priority register block.
// Assumes irq_ctrl_consts.svh supplies the numeric constants.
package irq_ctrl_pkg;

  // Number of gated sources and register width
  localparam int NUM_SRC   = 14;
  localparam int REG_W     = 16;
  localparam int ADDR_W    = 8;

  // Write request from the bus port to the register file
  typedef struct packed {
    logic              fire;
    logic [ADDR_W-1:0] addr;
    logic [31:0]       data;
    logic [3:0]        strb;
  } wr_req_type;

  // Read request and its answer
  typedef struct packed {
    logic              fire;
    logic [ADDR_W-1:0] addr;
  } rd_req_type;

  typedef struct packed {
    logic              ok;
    logic [31:0]       data;
  } rd_ans_type;

endpackage

/* File: core/axil_reg_port.sv */
// AXI4-Lite slave front end: one write and one read in flight.
// Assumes the register file answers reads in the same cycle.
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"

module axil_reg_port
  import irq_ctrl_pkg::*;
(
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] awaddr,
  input  wire logic              awvalid,
  output logic                   awready,
  input  wire logic [31:0]       wdata,
  input  wire logic [3:0]        wstrb,
  input  wire logic              wvalid,
  output logic                   wready,
  output logic [1:0]             bresp,
  output logic                   bvalid,
  input  wire logic              bready,
  input  wire logic [ADDR_W-1:0] araddr,
  input  wire logic              arvalid,
  output logic                   arready,
  output logic [31:0]            rdata,
  output logic [1:0]             rresp,
  output logic                   rvalid,
  input  wire logic              rready,
  output wr_req_type             wr_req,
  input  wire logic              wr_ok,
  output rd_req_type             rd_req,
  input  rd_ans_type             rd_ans
);

  logic              aw_full_r;   // Write address held
  logic              w_full_r;    // Write data held
  logic [ADDR_W-1:0] awaddr_r;    // Held write address
  logic [31:0]       wdata_r;     // Held write data
  logic [3:0]        wstrb_r;     // Held byte strobes

  // Address and data are taken in either order, never twice per write
  assign awready = ~aw_full_r & ~bvalid;
  assign wready  = ~w_full_r & ~bvalid;
  assign arready = ~rvalid;

  // Write fires once both halves are held
  assign wr_req.fire = aw_full_r & w_full_r & ~bvalid;
  assign wr_req.addr = awaddr_r;
  assign wr_req.data = wdata_r;
  assign wr_req.strb = wstrb_r;

  // Read address goes straight to the register file
  assign rd_req.fire = arvalid & arready;
  assign rd_req.addr = araddr;

  // Write channel holding and response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_full_r <= 1'b0;
      w_full_r  <= 1'b0;
      awaddr_r  <= '0;
      wdata_r   <= '0;
      wstrb_r   <= '0;
      bvalid    <= 1'b0;
      bresp     <= `RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        aw_full_r <= 1'b1;
        awaddr_r  <= awaddr;
      end
      if (wvalid && wready) begin
        w_full_r <= 1'b1;
        wdata_r  <= wdata;
        wstrb_r  <= wstrb;
      end
      if (wr_req.fire) begin
        aw_full_r <= 1'b0;
        w_full_r  <= 1'b0;
        bvalid    <= 1'b1;
        bresp     <= wr_ok ? `RESP_OKAY : `RESP_DECERR;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end

  // Read channel: data captured at the address handshake
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rvalid <= 1'b0;
      rdata  <= '0;
      rresp  <= `RESP_OKAY;
    end else if (rd_req.fire) begin
      rvalid <= 1'b1;
      rdata  <= rd_ans.data;
      rresp  <= rd_ans.ok ? `RESP_OKAY : `RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end

endmodule // axil_reg_port

/* File: core/interrupt_enable_priority_regs.sv */
// Interrupt enable and priority registers for a group of peripheral
// sources, with sticky event status, mask and one interrupt output.
// Assumes request inputs are synchronous to aclk and held as levels
// by the peripherals until serviced.
//
// Operation
// - Enabled source passes its request onward
// - Disabled source request is blocked completely
// - Enable 6 layout: ADC, comparators, PWM
// - Enable 0 layout: compare, capture, ext 0
// - Three-bit ext priority, all ones highest
// - Unimplemented bits ignore writes, read zero
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"

module interrupt_enable_priority_regs
  import irq_ctrl_pkg::*;
(
  input  wire logic               aclk,
  input  wire logic               aresetn,
  // AXI4-Lite register port
  input  wire logic [ADDR_W-1:0]  awaddr,
  input  wire logic [2:0]         awprot,
  input  wire logic               awvalid,
  output logic                    awready,
  input  wire logic [31:0]        wdata,
  input  wire logic [3:0]         wstrb,
  input  wire logic               wvalid,
  output logic                    wready,
  output logic [1:0]              bresp,
  output logic                    bvalid,
  input  wire logic               bready,
  input  wire logic [ADDR_W-1:0]  araddr,
  input  wire logic [2:0]         arprot,
  input  wire logic               arvalid,
  output logic                    arready,
  output logic [31:0]             rdata,
  output logic [1:0]              rresp,
  output logic                    rvalid,
  input  wire logic               rready,
  // Peripheral request lines, one per source
  input  wire logic [NUM_SRC-1:0] src_req,
  // Gated requests toward priority evaluation
  output logic [NUM_SRC-1:0]      src_gated,
  // Active priority of the pending external sources
  output logic [2:0]              ext_irq3_level,
  output logic [2:0]              ext_irq4_level,
  output logic [2:0]              best_ext_level,
  // Level interrupt from unmasked sticky status
  output logic                    irq
);

  // ****************************************************************
  // Source numbering
  // ****************************************************************
  // Index of each source in the request, status and mask vectors.
  localparam int SRC_EXT0  = 0;
  localparam int SRC_IC1   = 1;
  localparam int SRC_OC1   = 2;
  localparam int SRC_PWM3  = 3;
  localparam int SRC_PWM4  = 4;
  localparam int SRC_PWM5  = 5;
  localparam int SRC_PWM6  = 6;
  localparam int SRC_CMP2  = 7;
  localparam int SRC_CMP3  = 8;
  localparam int SRC_CMP4  = 9;
  localparam int SRC_ADC0  = 10;
  localparam int SRC_ADC1  = 11;
  localparam int SRC_EXT3  = 12;
  localparam int SRC_EXT4  = 13;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  wr_req_type           wr_req;          // Write from bus port
  rd_req_type           rd_req;          // Read from bus port
  rd_ans_type           rd_ans;          // Read answer to bus port
  logic                 wr_ok;           // Write hit a mapped word

  logic [REG_W-1:0]     enable_0_r;      // interrupt_enable_0
  logic [REG_W-1:0]     enable_6_r;      // interrupt_enable_6
  logic [REG_W-1:0]     priority_13_r;   // interrupt_priority_13
  logic [REG_W-1:0]     irq_status_r;    // Sticky event status
  logic [REG_W-1:0]     irq_mask_r;      // Interrupt mask

  logic [REG_W-1:0]     byte_mask;       // Strobes widened to bits
  logic [REG_W-1:0]     wr_bits;         // Write data under strobes
  logic                 hit_en0;         // Write to enable 0
  logic                 hit_en6;         // Write to enable 6
  logic                 hit_prio;        // Write to priority 13
  logic                 hit_stat;        // Write to status
  logic                 hit_mask;        // Write to mask

  logic [2:0]           ext_irq3_priority; // Field view, ext 3
  logic [2:0]           ext_irq4_priority; // Field view, ext 4
  logic [NUM_SRC-1:0]   stat_bits_r;     // Sticky bit per source
  logic [NUM_SRC-1:0]   en_vec;          // Per-source enable
  logic [NUM_SRC-1:0]   gated_now;       // Request after enable
  logic [NUM_SRC-1:0]   src_event;       // Rising edge of gated
  logic [NUM_SRC-1:0]   stat_clr;        // Write-one-to-clear
  logic [2:0]           best_nxt;        // Next best ext level

  // ****************************************************************
  // Bus front end
  // ****************************************************************
  // The prot inputs carry no meaning here; every access is allowed.
  axil_reg_port i_axil_reg_port (
    .aclk    (aclk),
    .aresetn (aresetn),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .wr_req  (wr_req),
    .wr_ok   (wr_ok),
    .rd_req  (rd_req),
    .rd_ans  (rd_ans)
  );

  // ****************************************************************
  // Write decode
  // ****************************************************************
  // Only the two low byte lanes reach the 16-bit registers; the
  // upper lanes have nothing behind them and are simply dropped.
  assign byte_mask = {{8{wr_req.strb[1]}}, {8{wr_req.strb[0]}}};
  assign wr_bits   = wr_req.data[REG_W-1:0] & byte_mask;

  // Word decode ignores the two low address bits
  always_comb begin
    hit_en0  = 1'b0;
    hit_en6  = 1'b0;
    hit_prio = 1'b0;
    hit_stat = 1'b0;
    hit_mask = 1'b0;
    wr_ok    = 1'b1;
    unique case ({wr_req.addr[ADDR_W-1:2], 2'b00})
      `OFS_ENABLE_0:    hit_en0  = wr_req.fire;
      `OFS_ENABLE_6:    hit_en6  = wr_req.fire;
      `OFS_PRIORITY_13: hit_prio = wr_req.fire;
      `OFS_IRQ_STATUS:  hit_stat = wr_req.fire;
      `OFS_IRQ_MASK:    hit_mask = wr_req.fire;
      // Unmapped word: no effect, error response
      default:          wr_ok    = 1'b0;
    endcase
  end

  // ****************************************************************
  // Enable registers
  // ****************************************************************
  // Enable 0: compare 1, capture 1, external 0 in the low bits.
  // Bits without a source are masked so they never store a one.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_0_r <= `RST_ENABLE;
    end else if (hit_en0) begin
      enable_0_r <= ((enable_0_r & ~byte_mask) | wr_bits)
                    & `IMPL_ENABLE_0;
    end
  end

  // Enable 6: ADC pairs, comparators 2 to 4, PWM 3 to 6
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      enable_6_r <= `RST_ENABLE;
    end else if (hit_en6) begin
      enable_6_r <= ((enable_6_r & ~byte_mask) | wr_bits)
                    & `IMPL_ENABLE_6;
    end
  end

  // ****************************************************************
  // Priority register
  // ****************************************************************
  // Both external priority fields come out of reset at level 4, so
  // those sources are live until software lowers them to zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      priority_13_r <= `RST_PRIORITY_13;
    end else if (hit_prio) begin
      priority_13_r <= ((priority_13_r & ~byte_mask) | wr_bits)
                       & `IMPL_PRIORITY_13;
    end
  end

  // Field views: the code is the level, 7 highest, 1 lowest
  assign ext_irq4_priority = priority_13_r[`POS_EXT4_PRIO +: 3];
  assign ext_irq3_priority = priority_13_r[`POS_EXT3_PRIO +: 3];

  // ****************************************************************
  // Request gating
  // ****************************************************************
  // Each source is enabled by its own bit; the two external sources
  // with a priority field are enabled by any non-zero code.
  always_comb begin
    en_vec           = '0;
    en_vec[SRC_EXT0] = enable_0_r[`POS_EXT_IRQ0];
    en_vec[SRC_IC1]  = enable_0_r[`POS_IN_CAP1];
    en_vec[SRC_OC1]  = enable_0_r[`POS_OUT_CMP1];
    en_vec[SRC_PWM3] = enable_6_r[`POS_PWM3];
    en_vec[SRC_PWM4] = enable_6_r[`POS_PWM4];
    en_vec[SRC_PWM5] = enable_6_r[`POS_PWM5];
    en_vec[SRC_PWM6] = enable_6_r[`POS_PWM6];
    en_vec[SRC_CMP2] = enable_6_r[`POS_CMP2];
    en_vec[SRC_CMP3] = enable_6_r[`POS_CMP3];
    en_vec[SRC_CMP4] = enable_6_r[`POS_CMP4];
    en_vec[SRC_ADC0] = enable_6_r[`POS_ADC_PAIR0];
    en_vec[SRC_ADC1] = enable_6_r[`POS_ADC_PAIR1];
    en_vec[SRC_EXT3] = |ext_irq3_priority;
    en_vec[SRC_EXT4] = |ext_irq4_priority;
  end

  // A request passes only while its enable is set
  assign gated_now = src_req & en_vec;

  // Registered so the evaluation side sees clean flip-flop outputs;
  // costs one cycle of latency from request to gated output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_gated <= '0;
    end else begin
      src_gated <= gated_now;
    end
  end

  // ****************************************************************
  // Priority evaluation of the external sources
  // ****************************************************************
  // A pending external source presents its level; otherwise zero.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ext_irq3_level <= 3'h0;
      ext_irq4_level <= 3'h0;
    end else begin
      ext_irq3_level <= gated_now[SRC_EXT3] ? ext_irq3_priority
                                            : 3'h0;
      ext_irq4_level <= gated_now[SRC_EXT4] ? ext_irq4_priority
                                            : 3'h0;
    end
  end

  // Higher code wins; zero means nothing external is pending
  always_comb begin
    best_nxt = 3'h0;
    if (gated_now[SRC_EXT3]) begin
      best_nxt = ext_irq3_priority;
    end
    if (gated_now[SRC_EXT4] && ext_irq4_priority > best_nxt) begin
      best_nxt = ext_irq4_priority;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      best_ext_level <= 3'h0;
    end else begin
      best_ext_level <= best_nxt;
    end
  end

  // ****************************************************************
  // Sticky status, mask and interrupt
  // ****************************************************************
  // An event is the first cycle a gated request is seen high; a
  // held level does not retrigger after software clears the bit.
  assign src_event = gated_now & ~src_gated;
  assign stat_clr  = hit_stat ? wr_bits[NUM_SRC-1:0]
                              : {NUM_SRC{1'b0}};

  // One sticky bit per source; set beats a clear in the same cycle
  // so no event is ever lost to a racing software clear.
  generate
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_stat
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          stat_bits_r[i] <= 1'b0;
        end else if (src_event[i]) begin
          stat_bits_r[i] <= 1'b1;
        end else if (stat_clr[i]) begin
          stat_bits_r[i] <= 1'b0;
        end
      end
    end
  endgenerate

  // Status bits above the last source do not exist
  assign irq_status_r = {{(REG_W-NUM_SRC){1'b0}}, stat_bits_r};

  // Mask: a one lets the matching status bit raise irq
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq_mask_r <= `RST_IRQ_MASK;
    end else if (hit_mask) begin
      irq_mask_r <= ((irq_mask_r & ~byte_mask) | wr_bits)
                    & `IMPL_IRQ_BITS;
    end
  end

  // Level output, registered so it is glitch free
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_status_r & irq_mask_r);
    end
  end

  // ****************************************************************
  // Read mux
  // ****************************************************************
  // Registers sit in the low half; the upper half reads as zero.
  // Reads have no side effect on any register.
  always_comb begin
    rd_ans.ok   = 1'b1;
    rd_ans.data = 32'h0000_0000;
    unique case ({rd_req.addr[ADDR_W-1:2], 2'b00})
      `OFS_ENABLE_0:    rd_ans.data[REG_W-1:0] = enable_0_r;
      `OFS_ENABLE_6:    rd_ans.data[REG_W-1:0] = enable_6_r;
      `OFS_PRIORITY_13: rd_ans.data[REG_W-1:0] = priority_13_r;
      `OFS_IRQ_STATUS:  rd_ans.data[REG_W-1:0] = irq_status_r;
      `OFS_IRQ_MASK:    rd_ans.data[REG_W-1:0] = irq_mask_r;
      // Unmapped word: zero data, error response
      default:          rd_ans.ok = 1'b0;
    endcase
  end

endmodule // interrupt_enable_priority_regs

/* File: bench/irq_ctrl_properties.sv */
// Port checker for the interrupt enable and priority block.
// Assumes it is bound to interrupt_enable_priority_regs, one clock.
`timescale 1ns/1ps

module irq_ctrl_properties
  import irq_ctrl_pkg::*;
(
  input wire logic               aclk,
  input wire logic               aresetn,
  input wire logic [NUM_SRC-1:0] src_req,
  input wire logic [NUM_SRC-1:0] src_gated,
  input wire logic [2:0]         ext_irq3_level,
  input wire logic [2:0]         ext_irq4_level,
  input wire logic [2:0]         best_ext_level,
  input wire logic               bvalid,
  input wire logic               bready,
  input wire logic [1:0]         bresp,
  input wire logic               rvalid,
  input wire logic               rready,
  input wire logic [31:0]        rdata,
  input wire logic               irq
);
  // ****************************************************************
  // Clocking and helper logic
  // ****************************************************************
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  logic [2:0] top_level;  // Larger of the two external levels
  assign top_level = (ext_irq3_level > ext_irq4_level) ?
                     ext_irq3_level : ext_irq4_level;

  // ****************************************************************
  // Properties
  // ****************************************************************
  // A gated bit never appears without its request one edge before
  gated_by_req_a: assert property (
    (src_gated & ~$past(src_req)) == 14'h0000)
    else $error("gated request without a request");
  ext3_enabled_a: assert property (
    ext_irq3_level != 3'h0 |-> src_gated[12])
    else $error("ext 3 level while not gated");
  ext4_enabled_a: assert property (
    ext_irq4_level != 3'h0 |-> src_gated[13])
    else $error("ext 4 level while not gated");
  ext_idle_a: assert property (
    !$past(src_req[12]) && !$past(src_req[13]) |->
    ext_irq3_level == 3'h0 && ext_irq4_level == 3'h0)
    else $error("ext level without a request");
  best_level_a: assert property (
    best_ext_level == top_level)
    else $error("best level is not the largest");
  read_upper_a: assert property (
    rvalid |-> rdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  // Answers must stand until taken, or the master loses them
  resp_stand_a: assert property (
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write answer dropped early");
  read_stand_a: assert property (
    rvalid && !rready |=> rvalid && $stable(rdata))
    else $error("read answer dropped early");
  reset_clear_a: assert property (
    $rose(aresetn) |-> src_gated == 14'h0000 && !irq && !bvalid)
    else $error("outputs not clear after reset");
endmodule  // irq_ctrl_properties

bind interrupt_enable_priority_regs irq_ctrl_properties
  i_irq_ctrl_properties (.aclk(aclk), .aresetn(aresetn),
  .src_req(src_req), .src_gated(src_gated),
  .ext_irq3_level(ext_irq3_level), .ext_irq4_level(ext_irq4_level),
  .best_ext_level(best_ext_level), .bvalid(bvalid), .bready(bready),
  .bresp(bresp), .rvalid(rvalid), .rready(rready), .rdata(rdata),
  .irq(irq));

/* File: bench/test_interrupt_enable_priority_regs.sv */
// Self-checking bench for the interrupt enable and priority block.
// Assumes the checker is bound to the design by its own file.
`timescale 1ns/1ps
`include "irq_ctrl_consts.svh"

module test_interrupt_enable_priority_regs;
  import irq_ctrl_pkg::*;
  // ****************************************************************
  // Signals
  // ****************************************************************
  logic               aclk = 1'b0;
  logic               aresetn = 1'b0;
  logic [7:0]         awaddr = 8'h00, araddr = 8'h00;
  logic               awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  logic               arvalid = 1'b0, rready = 1'b0;
  logic [31:0]        wdata = 32'h0;
  logic [3:0]         wstrb = 4'hF;        // Write byte strobes
  logic [NUM_SRC-1:0] src_req = 14'h0000;  // Peripheral requests
  logic               awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0]         bresp, rresp, r;
  logic [31:0]        rdata, d;
  logic [NUM_SRC-1:0] src_gated;
  logic [2:0]         l3, l4, lb;
  int                 num_errors = 0, n_tests = 0;

  interrupt_enable_priority_regs i_interrupt_enable_priority_regs (
    .aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata),
    .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
    .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .src_req(src_req), .src_gated(src_gated), .ext_irq3_level(l3),
    .ext_irq4_level(l4), .best_ext_level(lb), .irq(irq));

  // Free-running 200 MHz clock
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic close_out;
    $display("comparisons %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got,
               exp);
    end
  endtask

  // A bound that runs out ends the run as a failure
  task automatic give_up;
    num_errors++;
    close_out();
  endtask

  // AXI4-Lite write: address and data offered together
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    int k;
    @(posedge aclk);
    awaddr <= a;
    wdata <= v;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (k == 50) give_up();
    r = bresp;
    bready <= 1'b0;
  endtask

  // AXI4-Lite read; data and response taken at the answer edge
  task automatic rd(input logic [7:0] a);
    int k;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (k == 50) give_up();
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask

  // ****************************************************************
  // Scenarios
  // ****************************************************************
  // Reset values, then an unmapped place
  task automatic t_reset;
    rd(`OFS_ENABLE_0);    chk(d, 32'h0000);
    rd(`OFS_ENABLE_6);    chk(d, 32'h0000);
    rd(`OFS_PRIORITY_13); chk(d, 32'h0440);
    rd(8'h14);
    chk(d, 32'h0);
    chk(r, 2'h3);
    wr(8'h14, 32'hFFFFFFFF); chk(r, 2'h3);
    $display("test reset done");
  endtask

  // All ones written; only implemented bits come back
  task automatic t_bits;
    wr(`OFS_ENABLE_0, 32'hFFFFFFFF);    rd(`OFS_ENABLE_0);
    chk(d, 32'h0007);
    chk(r, 2'h0);
    wr(`OFS_ENABLE_6, 32'hFFFFFFFF);    rd(`OFS_ENABLE_6);
    chk(d, 32'hC38F);
    // Low lane only: the upper byte must keep its ones
    wstrb <= 4'h1;
    wr(`OFS_ENABLE_6, 32'h0);
    rd(`OFS_ENABLE_6);
    chk(d, 32'hC300);
    wstrb <= 4'hF;
    wr(`OFS_PRIORITY_13, 32'hFFFFFFFF); rd(`OFS_PRIORITY_13);
    chk(d, 32'h0770);
    $display("test bits done");
  endtask

  // One enable at a time, with the requests of sources 0 to 11 held high
  task automatic t_gate;
    int i, b;
    src_req <= 14'h0FFF;
    for (i = 0; i < 12; i++) begin
      b = (i < 3 || (i > 6 && i < 10)) ? i : (i < 7) ? i - 3 : i + 4;
      wr(`OFS_ENABLE_0, (i < 3) ? 32'h1 << b : 32'h0);
      wr(`OFS_ENABLE_6, (i < 3) ? 32'h0 : 32'h1 << b);
      repeat (2) @(posedge aclk);
      chk(src_gated, 32'h1 << i);
    end
    wr(`OFS_ENABLE_6, 32'h0);
    repeat (2) @(posedge aclk);
    chk(src_gated, 32'h0);
    $display("test gate done");
  endtask

  // Every priority code on both external fields
  task automatic t_prio;
    int c;
    src_req <= 14'h3000;
    for (c = 0; c < 8; c++) begin
      wr(`OFS_PRIORITY_13, (c << 8) | ((7 - c) << 4));
      repeat (2) @(posedge aclk);
      chk({l4, l3}, {c[2:0], 3'(7 - c)});
      chk(lb, (c > 3) ? c : 7 - c);
      chk(src_gated[13:12], {c != 0, c != 7});
    end
    $display("test priority done");
  endtask

  // Sticky event, mask, level output and write-one clear
  task automatic t_irq;
    src_req <= 14'h0000;
    wr(`OFS_ENABLE_0, 32'h1);
    wr(`OFS_IRQ_STATUS, 32'h3FFF);
    src_req <= 14'h0001;
    repeat (3) @(posedge aclk);
    src_req <= 14'h0000;
    rd(`OFS_IRQ_STATUS); chk(d, 32'h1);
    chk(irq, 1'b0);
    wr(`OFS_IRQ_MASK, 32'h1);
    chk(r, 2'h0);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`OFS_IRQ_STATUS, 32'h1);
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    rd(`OFS_IRQ_STATUS); chk(d, 32'h0);
    $display("test interrupt done");
  endtask

  // Main sequence: reset held 4 cycles, then each scenario
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_bits();
    t_gate();
    t_prio();
    t_irq();
    close_out();
  end
endmodule  // test_interrupt_enable_priority_regs
